//--- rtl/spmp_pkg.sv
// Purpose: shared constants and types of the serial master/slave port
// Assumes: one core clock; all sizes fixed
// Notes:   word length field holds bits minus one
package spmp_pkg;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned LEN_W      = 4;
    localparam int unsigned SEL_W      = 2;
    localparam int unsigned NUM_SEL    = 4;
    localparam int unsigned WCNT_W     = 4;
    localparam int unsigned BAUD_W     = 8;
    localparam int unsigned HALF_W     = 11;
    // low-speed peripheral clock prescalers of the two variants
    localparam logic [2:0]  LSP_DIV_A  = 3'h4;
    localparam logic [2:0]  LSP_DIV_B  = 3'h6;
    localparam logic [NUM_SEL-1:0] SEL_IDLE = 4'hF;
    localparam logic [WORD_W-1:0]  WORD_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_CLK_A = 3'b010,
        ST_CLK_B = 3'b011,
        ST_WORD  = 3'b100,
        ST_HOLD  = 3'b101
    } spmp_state_t;
endpackage

//--- rtl/spmp_shift_if.sv
// Purpose: bundle between the port sequencer and its shift register
// Assumes: strobes are one core clock wide
// Notes:   len is bits per word minus one
`timescale 1ns/1ps
`default_nettype none
interface spmp_shift_if;
    logic        load;
    logic        lead;
    logic        trail;
    logic        cpha;
    logic [3:0]  len;
    logic [15:0] tx;
    logic        sin;
    logic        sout;
    logic [15:0] rx;
    logic        done;

    modport ctl (output load, lead, trail, cpha, len, tx, sin, input sout, rx, done);
    modport sh  (input load, lead, trail, cpha, len, tx, sin, output sout, rx, done);
endinterface
`default_nettype wire

//--- rtl/spmp_shifter.sv
// Purpose: msb-first shift register with phase-dependent shift and sample
// Assumes: lead and trail never arrive in the same cycle
// Notes:   load wins over any edge in the same cycle
`timescale 1ns/1ps
`default_nettype none
module spmp_shifter (
    input wire logic clk,
    input wire logic rst,
    spmp_shift_if.sh sh
);
    import spmp_pkg::*;

    logic [WORD_W-1:0] sreg;
    logic [WORD_W-1:0] rxs;
    logic [LEN_W-1:0]  cnt;
    logic              first;
    logic              pend;

    wire sample_ev = sh.cpha ? sh.lead : sh.trail;
    // shift on the opposite edge; pend drops a stale trail after reload
    wire shift_ev  = sh.cpha ? (sh.trail && pend) : (sh.lead && !first);
    wire last_bit  = (cnt == sh.len);

    // msb of the active length goes out first
    assign sh.sout = sreg[sh.len];
    assign sh.rx   = rxs;

    // rx cleared on load so short words land right-aligned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sreg    <= WORD_RST;
            rxs     <= WORD_RST;
            cnt     <= '0;
            first   <= 1'b1;
            pend    <= 1'b0;
            sh.done <= 1'b0;
        end else if (sh.load) begin
            sreg    <= sh.tx;
            rxs     <= WORD_RST;
            cnt     <= '0;
            first   <= 1'b1;
            pend    <= 1'b0;
            sh.done <= 1'b0;
        end else begin
            sh.done <= sample_ev && last_bit;
            if (sample_ev) begin
                rxs  <= {rxs[WORD_W-2:0], sh.sin};
                cnt  <= last_bit ? '0 : cnt + 4'h1;
                pend <= 1'b1;
            end
            if (sh.lead) begin
                first <= 1'b0;
            end
            if (shift_ev) begin
                sreg <= {sreg[WORD_W-2:0], 1'b0};
                pend <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/spmp_port.sv
// Purpose: serial port that runs as shift-clock master or follows a master
// Assumes: in slave role the incoming shift clock is far slower than clk
// Notes:   every pin input is taken as synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module spmp_port #(
    parameter bit LSP_VARIANT_B = 1'b0
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              role_master,
    input  wire logic                              cpol,
    input  wire logic                              cpha,
    input  wire logic [spmp_pkg::LEN_W-1:0]        word_len,
    input  wire logic [spmp_pkg::BAUD_W-1:0]       baud_div,
    input  wire logic [spmp_pkg::SEL_W-1:0]        slave_count,
    input  wire logic [15:0]                       words_per_slave,
    input  wire logic                              step_start,
    input  wire logic [spmp_pkg::WORD_W-1:0]       tx_data,
    output logic                                   tx_take,
    output logic [spmp_pkg::WORD_W-1:0]            rx_data,
    output logic [spmp_pkg::SEL_W-1:0]             rx_slave,
    output logic                                   word_valid,
    output logic                                   valid,
    output logic                                   overrun,
    input  wire logic                              overrun_clear,
    input  wire logic                              rx_read,
    input  wire logic                              serial_shift_clock_in,
    output logic                                   serial_shift_clock_out,
    output logic                                   serial_shift_clock_oe_n,
    input  wire logic                              master_out_line_in,
    output logic                                   master_out_line_out,
    output logic                                   master_out_line_oe_n,
    input  wire logic                              master_in_line_in,
    output logic                                   master_in_line_out,
    output logic                                   master_in_line_oe_n,
    output logic [spmp_pkg::NUM_SEL-1:0]           chip_select_n,
    input  wire logic                              dedicated_slave_enable_pin_n
);
    import spmp_pkg::*;

    spmp_shift_if sif ();

    spmp_state_t       state;
    spmp_state_t       next_state;
    logic [HALF_W-1:0] half_cnt;
    logic [LEN_W-1:0]  bit_cnt;
    logic [WCNT_W-1:0] word_cnt;
    logic [SEL_W-1:0]  cur_sel;
    logic              sclk_act;
    logic              prev_lvl;
    logic              prev_sel_n;
    logic              unread;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // half period = prescaler * (baud_div + 1) core clocks
    wire [2:0]        lsp_div  = LSP_VARIANT_B ? LSP_DIV_B : LSP_DIV_A;
    wire [HALF_W-1:0] half_len = HALF_W'(lsp_div) * (HALF_W'(baud_div) + 11'h001);
    wire              tick     = (half_cnt == half_len - 11'h001);
    wire              m_busy   = (state != ST_IDLE);

    // per-slave word count, field holds words minus one
    wire [WCNT_W-1:0] words_sel = words_per_slave[{cur_sel, 2'b00} +: WCNT_W];
    wire              last_word = (word_cnt == words_sel);
    wire              last_sel  = (cur_sel == slave_count);

    // slave edges come only from the external clock while selected
    wire s_active = !role_master && !dedicated_slave_enable_pin_n;
    wire s_lvl    = serial_shift_clock_in ^ cpol;
    wire s_lead   = s_active && s_lvl && !prev_lvl;
    wire s_trail  = s_active && !s_lvl && prev_lvl;
    wire s_load   = s_active && (prev_sel_n || sif.done);

    // master edge strobes
    wire m_lead   = role_master && (state == ST_CLK_A) && tick;
    wire m_trail  = role_master && (state == ST_CLK_B) && tick;
    wire m_load   = role_master && (((state == ST_IDLE) && step_start) ||
                                    ((state == ST_WORD) && !last_word));

    // shift register hookup, one shifter serves both roles
    assign sif.load  = m_load || s_load;
    assign sif.lead  = m_lead || s_lead;
    assign sif.trail = m_trail || s_trail;
    assign sif.cpha  = cpha;
    assign sif.len   = word_len;
    assign sif.tx    = tx_data;
    assign sif.sin   = role_master ? master_in_line_in : master_out_line_in;
    assign tx_take   = sif.load;

    // idle level equals polarity; active half is its inverse
    assign serial_shift_clock_out  = cpol ^ sclk_act;
    assign serial_shift_clock_oe_n = !role_master;
    assign master_out_line_out     = sif.sout;
    assign master_out_line_oe_n    = !role_master;
    // slave output line only driven while selected
    assign master_in_line_out      = sif.sout;
    assign master_in_line_oe_n     = !s_active;
    // one active-low select per slave, only during a step
    assign chip_select_n = (role_master && m_busy) ? ~(4'h1 << cur_sel) : SEL_IDLE;

    // master sequencer, same for every polarity and phase
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (role_master && step_start) next_state = ST_SETUP;
            ST_SETUP: if (tick) next_state = ST_CLK_A;
            ST_CLK_A: if (tick) next_state = ST_CLK_B;
            ST_CLK_B: if (tick) next_state = (bit_cnt == word_len) ? ST_WORD : ST_CLK_A;
            ST_WORD:  next_state = last_word ? ST_HOLD : ST_CLK_A;
            // select released half a period after the last edge
            ST_HOLD:  if (tick) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // state and half-period timer; timer restarts on each phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            half_cnt <= '0;
        end else begin
            state    <= role_master ? next_state : ST_IDLE;
            half_cnt <= (tick || !m_busy || state == ST_WORD) ? '0 : half_cnt + 11'h001;
        end
    end

    // bit, word and slave counters of the master
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt  <= '0;
            word_cnt <= '0;
            cur_sel  <= '0;
            sclk_act <= 1'b0;
        end else begin
            if (m_lead) sclk_act <= 1'b1;
            if (m_trail || !role_master) sclk_act <= 1'b0;
            if (m_trail) bit_cnt <= (bit_cnt == word_len) ? '0 : bit_cnt + 4'h1;
            if (state == ST_IDLE) word_cnt <= '0;
            else if (m_load) word_cnt <= word_cnt + 4'h1;
            // next step goes to the next slave, wrapping
            if ((state == ST_HOLD) && tick) cur_sel <= last_sel ? '0 : cur_sel + 2'h1;
            if (cur_sel > slave_count) cur_sel <= '0;
        end
    end

    // slave-side edge history; pins taken as already synchronous
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_lvl   <= 1'b0;
            prev_sel_n <= 1'b1;
        end else begin
            prev_lvl   <= s_lvl;
            prev_sel_n <= role_master ? 1'b1 : dedicated_slave_enable_pin_n;
        end
    end

    // each word lands in one cycle, so reads never stall the line
    wire ovr_master = role_master && step_start && m_busy;
    wire ovr_slave  = !role_master && sif.done && unread;

    // received words and flags; a new event beats a same-cycle clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_data    <= WORD_RST;
            rx_slave   <= '0;
            word_valid <= 1'b0;
            valid      <= 1'b0;
            overrun    <= 1'b0;
            unread     <= 1'b0;
        end else begin
            word_valid <= sif.done;
            if (sif.done) begin
                rx_data  <= sif.rx;
                rx_slave <= role_master ? cur_sel : '0;
            end
            // slave pulses per word, master at end of step
            valid   <= role_master ? ((state == ST_HOLD) && tick) : sif.done;
            overrun <= ovr_master || ovr_slave || (overrun && !overrun_clear);
            unread  <= (!role_master && sif.done) || (unread && !rx_read);
        end
    end

    a_idle_sel_high: assert property (!m_busy |-> chip_select_n == SEL_IDLE)
        else $error("select low while idle");
    a_single_sel: assert property ($onehot0(~chip_select_n))
        else $error("more than one select low");
    a_sclk_idle: assert property (role_master && (state == ST_IDLE || state == ST_SETUP)
                                  |-> serial_shift_clock_out == cpol)
        else $error("shift clock not at idle level");
    a_master_ovr: assert property (ovr_master |=> overrun)
        else $error("master overrun not flagged");
    a_slave_ovr: assert property (!role_master && sif.done && unread |=> overrun)
        else $error("slave overrun not flagged");
    a_slave_valid: assert property (!role_master && sif.done |=> valid && word_valid && rx_data == $past(sif.rx))
        else $error("slave valid missing");
    a_slave_line_oe: assert property (dedicated_slave_enable_pin_n |-> master_in_line_oe_n)
        else $error("slave drives while deselected");
    a_slave_no_clk: assert property (!role_master |-> serial_shift_clock_oe_n && !m_lead && !m_trail)
        else $error("slave generated a clock edge");
    a_lead_spacing: assert property (m_lead |=> !sif.lead [*3])
        else $error("shift edges closer than prescaler");
    a_word_len: assert property (m_trail && bit_cnt == word_len |=> state == ST_WORD)
        else $error("word not closed at set length");
    a_master_done: assert property (role_master && state == ST_WORD && cpha == 1'b0 |-> sif.done)
        else $error("capture missing on trailing edge");

    spmp_shifter u_shifter (
        .clk (clk),
        .rst (rst),
        .sh  (sif)
    );
endmodule
`default_nettype wire

//--- dv/spmp_slave_model.sv
// Purpose: behavioural serial slave hung on one select line
// Assumes: select stays low across all words of one step
// Notes:   unselected output shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module spmp_slave_model (
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        cs_n,
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic [3:0]  len,
    input  wire logic [15:0] tx,
    output logic             miso,
    output logic [15:0]      rx
);
    logic [15:0] sh = 16'h0000;
    logic [15:0] acc;
    int          cnt;
    // data line only meaningful while selected
    assign miso = cs_n ? ~sh[len] : sh[len];
    // fresh word at each select fall
    always @(negedge cs_n) begin
        sh = tx;
        cnt = 0;
    end
    // moves only on the master clock, msb first
    always @(sclk) begin
        if (cs_n == 1'b0) begin
            if ((sclk != cpol) == cpha) begin
                acc = {acc[14:0], mosi};
                cnt = cnt + 1;
                if (cnt == len + 1) rx = 16'(acc & ((32'h1 << (len + 5'h1)) - 32'h1));
            end else if (cnt == len + 1) begin
                sh = tx;
                cnt = 0;
            end else if (cnt != 0) begin
                sh = sh << 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/spmp_port_tb.sv
// Purpose: self-checking bench of the serial port in both roles
// Assumes: two model slaves on selects 0 and 1
// Notes:   bench also plays the external master in slave role
`timescale 1ns/1ps
`default_nettype none
module spmp_port_tb;
    import spmp_pkg::*;
    logic clk, rst, role_master, cpol, cpha, step_start, overrun_clear, rx_read, s_clk, s_mosi, s_cs;
    logic [3:0]  word_len;
    logic [7:0]  baud_div;
    logic [1:0]  slave_count, rx_slave;
    logic [15:0] words_per_slave, tx_data, rx_data;
    logic        tx_take, word_valid, valid, overrun, m0, m1, sclk_w, mosi_w, miso_w, sclk_q;
    logic        sco, sco_n, moo, moo_n, mio, mio_n;
    logic [3:0]  chip_select_n;
    logic [15:0] srx [2];
    logic [15:0] stx [2] = '{16'hB4E1, 16'h5A3C};
    logic [15:0] rx_w [64];
    logic [1:0]  rx_s [64];
    int          fail_count = 0, compares = 0, take_n = 0, rx_n = 0, sv_n = 0, gap = 0, last_gap = 0;
    // wire levels from whoever has the enable low
    assign sclk_w = !sco_n ? sco : s_clk;
    assign mosi_w = !moo_n ? moo : s_mosi;
    assign miso_w = !mio_n ? mio : (chip_select_n[0] ? m1 : m0);
    spmp_port dut (.clk(clk), .rst(rst), .role_master(role_master), .cpol(cpol), .cpha(cpha),
        .word_len(word_len), .baud_div(baud_div), .slave_count(slave_count), .words_per_slave(words_per_slave),
        .step_start(step_start), .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_slave(rx_slave),
        .word_valid(word_valid), .valid(valid), .overrun(overrun), .overrun_clear(overrun_clear),
        .rx_read(rx_read), .serial_shift_clock_in(sclk_w), .serial_shift_clock_out(sco),
        .serial_shift_clock_oe_n(sco_n), .master_out_line_in(mosi_w), .master_out_line_out(moo),
        .master_out_line_oe_n(moo_n), .master_in_line_in(miso_w), .master_in_line_out(mio),
        .master_in_line_oe_n(mio_n), .chip_select_n(chip_select_n), .dedicated_slave_enable_pin_n(s_cs));
    spmp_slave_model sl0 (.sclk(sclk_w), .mosi(mosi_w), .cs_n(chip_select_n[0]), .cpol(cpol), .cpha(cpha),
        .len(word_len), .tx(stx[0]), .miso(m0), .rx(srx[0]));
    spmp_slave_model sl1 (.sclk(sclk_w), .mosi(mosi_w), .cs_n(chip_select_n[1]), .cpol(cpol), .cpha(cpha),
        .len(word_len), .tx(stx[1]), .miso(m1), .rx(srx[1]));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [15:0] txw(input int k);
        txw = 16'(32'h9C35 ^ (k * 32'h2F1B));
    endfunction
    function automatic logic [15:0] msk(input logic [15:0] v);
        msk = v & 16'((32'h1 << (word_len + 5'h1)) - 32'h1);
    endfunction
    // word source, received log and shift clock spacing
    always @(negedge clk) tx_data <= txw(take_n);
    always @(posedge clk) begin
        if (tx_take === 1'b1) take_n <= take_n + 1;
        if (valid === 1'b1) sv_n <= sv_n + 1;
        if (word_valid === 1'b1) begin
            rx_w[rx_n] <= rx_data;
            rx_s[rx_n] <= rx_slave;
            rx_n <= rx_n + 1;
        end
        gap <= (sclk_w != sclk_q) ? 0 : gap + 1;
        if (sclk_w != sclk_q) last_gap <= gap + 1;
        sclk_q <= sclk_w;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic pulse_step();
        step_start = 1'b1;
        @(negedge clk) step_start = 1'b0;
    endtask
    // one master step towards slave sl carrying w words
    task automatic step(input int sl, input int w);
        logic [3:0] seen;
        int n, b;
        seen = 4'hF;
        n = 0;
        b = rx_n;
        pulse_step();
        while (valid !== 1'b1 && n < 5000) begin
            seen = seen & chip_select_n;
            @(negedge clk);
            n++;
        end
        // a step that never ends counts against the run
        chk(16'(n < 5000), 16'h0001);
        chk(16'(seen), {12'h000, ~(4'h1 << sl)});
        @(negedge clk);
        chk(16'(chip_select_n), 16'h000F);
        chk(16'(sclk_w), 16'(cpol));
        chk(16'(last_gap), 16'(4 * (baud_div + 1)));
        chk(16'(rx_n - b), 16'(w));
        for (int i = b; i < rx_n; i++) chk(rx_w[i], msk(stx[sl]));
        chk(16'(rx_s[b]), 16'(sl));
        chk(srx[sl], msk(txw(take_n - 1)));
    endtask
    // bench as external master in the current scheme
    task automatic sword(input logic [15:0] d);
        logic [15:0] got, e;
        int v;
        got = 16'h0000;
        s_clk = cpol;
        // deselect gap, else back-to-back words never show a select fall
        repeat (2) @(negedge clk);
        e = msk(txw(take_n));
        v = sv_n;
        chk(16'(mio_n), 16'h0001);
        s_cs = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = word_len; i >= 0; i--) begin
            // early phase: data stands before the leading edge
            if (cpha) s_mosi = d[i];
            repeat (4) @(negedge clk);
            if (cpha) got = {got[14:0], mio};
            s_clk = !cpol;
            if (!cpha) s_mosi = d[i];
            repeat (4) @(negedge clk);
            if (!cpha) got = {got[14:0], mio};
            s_clk = cpol;
        end
        chk(16'(mio_n), 16'h0000);
        repeat (4) @(negedge clk);
        s_cs = 1'b1;
        s_mosi = ~s_mosi;
        chk(got, e);
        chk(rx_data, msk(d));
        chk(16'(sv_n - v), 16'h0001);
    endtask
    initial begin
        {rst, role_master, s_cs, s_mosi} = 4'hF;
        {cpol, cpha, step_start, overrun_clear, rx_read, s_clk} = 6'h00;
        {word_len, baud_div, slave_count, words_per_slave} = {4'h7, 8'h01, 2'h1, 16'h0000};
        repeat (9) @(negedge clk);
        chk(16'(chip_select_n), 16'h000F);
        chk({overrun, valid, sco}, 3'h0);
        rst = 1'b0;
        // every scheme, two slaves in turn
        for (int m = 0; m < 4; m++) begin
            {cpol, cpha} = 2'(m);
            repeat (3) @(negedge clk);
            chk(16'(sco), 16'(cpol));
            step(0, 1);
            step(1, 1);
        end
        {cpol, cpha, word_len, words_per_slave} = {2'h0, 4'hF, 16'h0002};
        step(0, 3);
        step(1, 1);
        word_len = 4'h0;
        step(0, 3);
        // second request while busy
        pulse_step();
        repeat (3) @(negedge clk);
        pulse_step();
        chk(16'(overrun), 16'h0001);
        repeat (3000) @(negedge clk);
        overrun_clear = 1'b1;
        @(negedge clk) overrun_clear = 1'b0;
        chk(16'(overrun), 16'h0000);
        {role_master, cpha, word_len} = {1'b0, 1'b1, 4'h7};
        // slave is up before the bench starts its first word
        repeat (3) @(negedge clk);
        sword(16'h00C3);
        rx_read = 1'b1;
        @(negedge clk) rx_read = 1'b0;
        sword(16'h005A);
        chk(16'(overrun), 16'h0000);
        sword(16'h0096);
        chk(16'(overrun), 16'h0001);
        // falling scheme without delay in slave role
        {cpol, cpha} = 2'h2;
        sword(16'h0069);
        print_verdict();
    end
    // hang guard well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
